// ==== pkg/maf_defines.vh ====
// Constants for the receive address filter and backoff test block.
// Assumes a 20 MHz clock and byte addresses on the register port.
//
// Summary of operation
// - Six hash bits, each the XOR of every sixth destination address bit.
// - The hash picks one bit of a 64-bit table in two registers.
// - Low table register covers hashes 0-31, high register covers 32-63.
// - A non-broadcast group frame is accepted when multicast is enabled and its selected table bit is set.
// - Address high register holds address bits 16-47 in byte order.
// - Group bit of address high reads zero and ignores writes.
// - Reads of the backoff test register show the 11-bit generator.
// - Generator field is writable only while test mode is set.
// - Generator resets to zero and advances from the first clock after.
// - Attempt field counts collisions of the frame now being sent.
// - Backoff counter loads on collision, drops one per slot time.
// - Reserved bits 11-10 of backoff test read zero, writes dropped.
// - Low byte write disables the channel, high write re-enables it if any receive enable is set.
`ifndef MAF_DEFINES_VH
`define MAF_DEFINES_VH

// ==========================================================
// Register offsets
`define MAF_ADDR_W          8
`define MAF_OFS_ADDR_HIGH   8'h00
`define MAF_OFS_HASH_LOW    8'h04
`define MAF_OFS_HASH_HIGH   8'h08
`define MAF_OFS_BOFF_TEST   8'h0c
`define MAF_OFS_MAC_CTRL    8'h10
`define MAF_OFS_ADDR_LOW    8'h14
`define MAF_OFS_FILT_STAT   8'h18

// ==========================================================
// Reset values
`define MAF_RST_WORD        32'h0000_0000
`define MAF_RST_RNG         11'h000
`define MAF_RST_ATTEMPT     4'h0
`define MAF_RST_COUNT       10'h000

// ==========================================================
// Field positions
`define MAF_GROUP_BIT       0
`define MAF_BT_FREEZE       31
`define MAF_BT_ATT_HI       30
`define MAF_BT_ATT_LO       27
`define MAF_BT_RNG_HI       26
`define MAF_BT_RNG_LO       16
`define MAF_BT_RTY_HI       15
`define MAF_BT_RTY_LO       12
`define MAF_BT_CNT_HI       9
`define MAF_BT_CNT_LO       0
`define MAF_CTL_TEST        0
`define MAF_CTL_UNI_EN      1
`define MAF_CTL_MULTI_EN    2
`define MAF_CTL_BCAST_EN    3
`define MAF_DA_GROUP        40

// ==========================================================
// Timing
`define MAF_CLK_PERIOD_NS   50
`define MAF_SLOT_TIME_NS    5120
`define MAF_SLOT_CYCLES     (`MAF_SLOT_TIME_NS / `MAF_CLK_PERIOD_NS)
`define MAF_SLOT_CNT_W      7
`define MAF_BACKOFF_LIMIT   4'ha

`endif

// ==== hw/maf_hash.v ====
// Destination address hash and table lookup, purely combinational.
// Assumes the address arrives with its first byte in bits 47-40.
`timescale 1ns/10ps
module maf_hash
(
    input  wire [47:0] da_in,
    input  wire [63:0] table_in,
    output wire [5:0]  hash_out,
    output wire        hit_out
);

    // ==========================================================
    // Fold address into six bits
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1)
        begin : g_fold
            assign hash_out[i] = da_in[i] ^ da_in[i+6] ^ da_in[i+12]
                               ^ da_in[i+18] ^ da_in[i+24] ^ da_in[i+30]
                               ^ da_in[i+36] ^ da_in[i+42];
        end
    endgenerate

    // Low register holds 0-31 in table bits 31:0
    assign hit_out = table_in[hash_out];

endmodule

// ==== hw/maf_top.v ====
// Receive address filter and collision backoff test logic.
// Assumes a simple register port with read data one cycle later and
// frame events from the MAC core as one-cycle pulses on clk_in.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "maf_defines.vh"
module maf_top
(
    input  wire                   clk_in,
    input  wire                   rst_n_in,
    input  wire [`MAF_ADDR_W-1:0] reg_addr_in,
    input  wire [31:0]            reg_wdata_in,
    input  wire                   reg_wr_in,
    input  wire                   reg_rd_in,
    output reg  [31:0]            reg_rdata_out,
    input  wire                   rx_da_valid_in,
    input  wire [47:0]            rx_da_in,
    output reg                    rx_result_valid_out,
    output reg                    rx_accept_out,
    output reg  [5:0]             rx_hash_out,
    input  wire                   tx_frame_start_in,
    input  wire                   tx_collision_in,
    output wire [3:0]             tx_attempt_out,
    output wire                   tx_backoff_busy_out,
    output wire                   channel_enabled_out
);

    // ==========================================================
    // Register state
    reg [31:0] station_address_high;
    reg [7:0]  station_address_low_byte;
    reg [31:0] group_hash_table_low;
    reg [31:0] group_hash_table_high;
    reg [3:0]  mac_control_register;
    reg        backoff_freeze_bit;
    reg [3:0]  transmit_retry_tally;
    reg [10:0] backoff_random_generator;
    reg [3:0]  attempt_count;
    reg [9:0]  backoff_slot_counter;
    reg        channel_enable;
    reg [`MAF_SLOT_CNT_W-1:0] slot_div;
    reg        slot_tick;
    reg [1:0]  last_kind;

    wire wr_addr_high = reg_wr_in &&
                        (reg_addr_in == `MAF_OFS_ADDR_HIGH);
    wire wr_addr_low  = reg_wr_in &&
                        (reg_addr_in == `MAF_OFS_ADDR_LOW);
    wire wr_boff      = reg_wr_in &&
                        (reg_addr_in == `MAF_OFS_BOFF_TEST);
    wire test_mode    = mac_control_register[`MAF_CTL_TEST];
    wire any_rx_en    = mac_control_register[`MAF_CTL_UNI_EN] |
                        mac_control_register[`MAF_CTL_MULTI_EN] |
                        mac_control_register[`MAF_CTL_BCAST_EN];

    // ==========================================================
    // Software registers
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            station_address_high     <= `MAF_RST_WORD;
            station_address_low_byte <= 8'h00;
            group_hash_table_low     <= `MAF_RST_WORD;
            group_hash_table_high    <= `MAF_RST_WORD;
            mac_control_register     <= 4'h0;
            backoff_freeze_bit       <= 1'b0;
            transmit_retry_tally     <= 4'h0;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `MAF_OFS_ADDR_HIGH:
                begin
                    // Group bit forced low
                    station_address_high <= {reg_wdata_in[31:1], 1'b0};
                end
                `MAF_OFS_ADDR_LOW:
                begin
                    station_address_low_byte <= reg_wdata_in[7:0];
                end
                `MAF_OFS_HASH_LOW:
                begin
                    group_hash_table_low <= reg_wdata_in;
                end
                `MAF_OFS_HASH_HIGH:
                begin
                    group_hash_table_high <= reg_wdata_in;
                end
                `MAF_OFS_MAC_CTRL:
                begin
                    mac_control_register <= reg_wdata_in[3:0];
                end
                `MAF_OFS_BOFF_TEST:
                begin
                    // Stored only; no hardware acts on these two fields
                    backoff_freeze_bit   <= reg_wdata_in[`MAF_BT_FREEZE];
                    transmit_retry_tally <=
                        reg_wdata_in[`MAF_BT_RTY_HI:`MAF_BT_RTY_LO];
                end
                default:
                begin
                    station_address_high <= station_address_high;
                end
            endcase
        end
    end

    // ==========================================================
    // Channel enable
    // Address is rewritten piecewise, so matching pauses until high is done
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            channel_enable <= 1'b0;
        end
        else if (wr_addr_high)
        begin
            channel_enable <= any_rx_en;
        end
        else if (wr_addr_low)
        begin
            channel_enable <= 1'b0;
        end
    end

    assign channel_enabled_out = channel_enable;

    // ==========================================================
    // Receive filter
    wire [5:0] hash_val;
    wire       hash_hit;

    maf_hash u_hash
    (
        .da_in    (rx_da_in),
        .table_in ({group_hash_table_high, group_hash_table_low}),
        .hash_out (hash_val),
        .hit_out  (hash_hit)
    );

    // Register byte order is first address byte lowest
    wire [31:0] da_as_reg = {rx_da_in[23:16], rx_da_in[31:24],
                             rx_da_in[39:32], rx_da_in[47:40]};
    wire da_group = rx_da_in[`MAF_DA_GROUP];
    wire da_bcast = &rx_da_in;
    wire spec_hit = (da_as_reg == station_address_high) &&
                    (rx_da_in[7:0] == station_address_low_byte);
    reg  next_accept;

    always @*
    begin
        next_accept = 1'b0;
        if (da_group)
        begin
            if (da_bcast)
                next_accept = mac_control_register[`MAF_CTL_BCAST_EN];
            else
                next_accept = mac_control_register[`MAF_CTL_MULTI_EN]
                              & hash_hit;
        end
        else
        begin
            next_accept = mac_control_register[`MAF_CTL_UNI_EN]
                          & channel_enable & spec_hit;
        end
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_result_valid_out <= 1'b0;
            rx_accept_out       <= 1'b0;
            rx_hash_out         <= 6'h00;
            last_kind           <= 2'b00;
        end
        else
        begin
            rx_result_valid_out <= rx_da_valid_in;
            if (rx_da_valid_in)
            begin
                rx_accept_out <= next_accept;
                rx_hash_out   <= hash_val;
                last_kind     <= {da_group, next_accept};
            end
        end
    end

    // ==========================================================
    // Backoff random generator
    // Free-running count; collision timing makes its sample random enough
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            backoff_random_generator <= `MAF_RST_RNG;
        end
        else if (wr_boff && test_mode)
        begin
            backoff_random_generator <=
                reg_wdata_in[`MAF_BT_RNG_HI:`MAF_BT_RNG_LO];
        end
        else
        begin
            backoff_random_generator <=
                backoff_random_generator + 11'h001;
        end
    end

    // ==========================================================
    // Slot time divider
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            slot_div  <= {`MAF_SLOT_CNT_W{1'b0}};
            slot_tick <= 1'b0;
        end
        else if ({{(32-`MAF_SLOT_CNT_W){1'b0}}, slot_div} ==
                 (`MAF_SLOT_CYCLES - 1))
        begin
            slot_div  <= {`MAF_SLOT_CNT_W{1'b0}};
            slot_tick <= 1'b1;
        end
        else
        begin
            slot_div  <= slot_div + {{(`MAF_SLOT_CNT_W-1){1'b0}}, 1'b1};
            slot_tick <= 1'b0;
        end
    end

    // ==========================================================
    // Attempt count and backoff counter
    // Range doubles per collision up to ten bits, the usual truncation
    wire [3:0] next_attempt = (attempt_count == 4'hf) ? 4'hf :
                              attempt_count + 4'h1;
    wire [3:0] range_bits   = (next_attempt > `MAF_BACKOFF_LIMIT) ?
                              `MAF_BACKOFF_LIMIT : next_attempt;
    wire [10:0] range_mask  = (11'h001 << range_bits) - 11'h001;
    wire [10:0] draw        = backoff_random_generator & range_mask;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            attempt_count        <= `MAF_RST_ATTEMPT;
            backoff_slot_counter <= `MAF_RST_COUNT;
        end
        else if (tx_collision_in)
        begin
            // Collision wins over a frame start in the same cycle
            attempt_count        <= next_attempt;
            backoff_slot_counter <= draw[9:0];
        end
        else if (wr_boff && test_mode)
        begin
            attempt_count        <=
                reg_wdata_in[`MAF_BT_ATT_HI:`MAF_BT_ATT_LO];
            backoff_slot_counter <=
                reg_wdata_in[`MAF_BT_CNT_HI:`MAF_BT_CNT_LO];
        end
        else
        begin
            if (tx_frame_start_in)
                attempt_count <= `MAF_RST_ATTEMPT;
            if (slot_tick && (backoff_slot_counter != 10'h000))
                backoff_slot_counter <=
                    backoff_slot_counter - 10'h001;
        end
    end

    assign tx_attempt_out      = attempt_count;
    assign tx_backoff_busy_out = (backoff_slot_counter != 10'h000);

    // ==========================================================
    // Read port
    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (reg_addr_in)
            `MAF_OFS_ADDR_HIGH:
                next_rdata = station_address_high;
            `MAF_OFS_ADDR_LOW:
                next_rdata = {24'h000000, station_address_low_byte};
            `MAF_OFS_HASH_LOW:
                next_rdata = group_hash_table_low;
            `MAF_OFS_HASH_HIGH:
                next_rdata = group_hash_table_high;
            `MAF_OFS_MAC_CTRL:
                next_rdata = {28'h0000000, mac_control_register};
            `MAF_OFS_BOFF_TEST:
                next_rdata = {backoff_freeze_bit, attempt_count,
                              backoff_random_generator,
                              transmit_retry_tally,
                              2'b00,
                              backoff_slot_counter};
            `MAF_OFS_FILT_STAT:
                next_rdata = {22'h0, last_kind,
                              rx_hash_out, 1'b0, channel_enable};
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= next_rdata;
        end
        else
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule

// ==== tb/maf_checker_assertions.sv ====
// Port-level checks for maf_top, attached by bind.
// Assumes one clock domain and the offsets of maf_defines.vh.
`timescale 1ns/10ps
`include "maf_defines.vh"
module maf_checker
(
    input wire                   clk_in,
    input wire                   rst_n_in,
    input wire [`MAF_ADDR_W-1:0] reg_addr_in,
    input wire                   reg_wr_in,
    input wire                   reg_rd_in,
    input wire [31:0]            reg_rdata_out,
    input wire                   rx_da_valid_in,
    input wire [47:0]            rx_da_in,
    input wire                   rx_result_valid_out,
    input wire                   rx_accept_out,
    input wire [5:0]             rx_hash_out,
    input wire                   tx_frame_start_in,
    input wire                   tx_collision_in,
    input wire [3:0]             tx_attempt_out,
    input wire                   tx_backoff_busy_out,
    input wire                   channel_enabled_out
);
    // ====================
    // Reference hash, kept apart from the design's own
    function [5:0] ref_hash(input [47:0] v);
        integer k;
        begin
            ref_hash = 6'h00;
            for (k = 0; k < 48; k = k + 1)
                ref_hash[k % 6] = ref_hash[k % 6] ^ v[k];
        end
    endfunction
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ====================
    // Properties
    sequence s_first_hit;
        tx_collision_in && tx_attempt_out == 4'h0;
    endsequence
    sequence s_addr_taken;
        rx_da_valid_in ##1 rx_result_valid_out;
    endsequence
    property p_hash;
        s_addr_taken |-> rx_hash_out == ref_hash($past(rx_da_in));
    endproperty
    property p_held;
        !rx_da_valid_in |=> $stable(rx_hash_out) && $stable(rx_accept_out);
    endproperty
    property p_grp_bit;
        reg_rd_in && reg_addr_in == `MAF_OFS_ADDR_HIGH |=> !reg_rdata_out[0];
    endproperty
    property p_rsvd;
        reg_rd_in && reg_addr_in == `MAF_OFS_BOFF_TEST
            |=> reg_rdata_out[11:10] == 2'h0;
    endproperty
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == 32'h0;
    endproperty
    property p_att_step;
        tx_collision_in |=> tx_attempt_out == (($past(tx_attempt_out) == 4'hf)
            ? 4'hf : $past(tx_attempt_out) + 4'h1);
    endproperty
    property p_att_clr;
        tx_frame_start_in && !tx_collision_in |=> tx_attempt_out == 4'h0;
    endproperty
    property p_busy_rise;
        $rose(tx_backoff_busy_out) |-> $past(tx_collision_in || reg_wr_in);
    endproperty
    // First collision loads at most 1, so one slot time empties it
    property p_busy_drop;
        s_first_hit |=> ##[0:103] (!tx_backoff_busy_out || tx_collision_in);
    endproperty
    property p_chan_off;
        reg_wr_in && reg_addr_in == `MAF_OFS_ADDR_LOW |=> !channel_enabled_out;
    endproperty
    property p_chan_on;
        $rose(channel_enabled_out)
            |-> $past(reg_wr_in && reg_addr_in == `MAF_OFS_ADDR_HIGH);
    endproperty
    a_hash: assert property (p_hash) else $error("hash wrong");
    a_held: assert property (p_held) else $error("result moved");
    a_grp_bit: assert property (p_grp_bit)
        else $error("group bit set");
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    a_rd_idle: assert property (p_rd_idle)
        else $error("stale read");
    a_att_step: assert property (p_att_step)
        else $error("attempt");
    a_att_clr: assert property (p_att_clr)
        else $error("attempt kept");
    a_busy_rise: assert property (p_busy_rise) else $error("load");
    a_busy_drop: assert property (p_busy_drop)
        else $error("no drop");
    a_chan_off: assert property (p_chan_off)
        else $error("chan on");
    a_chan_on: assert property (p_chan_on) else $error("chan rose");
endmodule
bind maf_top maf_checker maf_checker_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rx_da_valid_in(rx_da_valid_in), .rx_da_in(rx_da_in),
    .rx_result_valid_out(rx_result_valid_out), .rx_accept_out(rx_accept_out),
    .rx_hash_out(rx_hash_out), .tx_frame_start_in(tx_frame_start_in),
    .tx_collision_in(tx_collision_in), .tx_attempt_out(tx_attempt_out),
    .tx_backoff_busy_out(tx_backoff_busy_out),
    .channel_enabled_out(channel_enabled_out));

// ==== tb/maf_mac_model.sv ====
// MAC-side event source: destination addresses and transmit events.
// Assumes the bench calls its tasks; outputs change after rising edges.
`timescale 1ns/10ps
module maf_mac_model
(
    input  wire        clk_in,
    output reg         rx_da_valid_out,
    output reg  [47:0] rx_da_out,
    output reg         tx_frame_start_out,
    output reg         tx_collision_out
);
    initial
    begin
        rx_da_valid_out = 1'h0;
        rx_da_out = 48'h0;
        tx_frame_start_out = 1'h0;
        tx_collision_out = 1'h0;
    end
    // ====================
    // Address inverted once valid drops, so late sampling shows up
    task send_da(input [47:0] v);
        begin
            @(posedge clk_in);
            rx_da_valid_out <= 1'h1;
            rx_da_out <= v;
            @(posedge clk_in);
            rx_da_valid_out <= 1'h0;
            rx_da_out <= ~v;
            #1;
        end
    endtask
    // One-cycle event: 0 starts a frame, 1 reports a collision
    task pulse(input is_col);
        begin
            @(posedge clk_in);
            if (is_col)
                tx_collision_out <= 1'h1;
            else
                tx_frame_start_out <= 1'h1;
            @(posedge clk_in);
            tx_collision_out <= 1'h0;
            tx_frame_start_out <= 1'h0;
            #1;
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for maf_top with a MAC-side event model.
// Assumes a 20 MHz clock and the offsets in maf_defines.vh.
`timescale 1ns/10ps
`include "maf_defines.vh"
module tb_top;
    reg         clk;
    reg         rst_n;
    reg  [7:0]  addr;
    reg  [31:0] wdata;
    reg         wr;
    reg         rd;
    wire [31:0] rdata;
    wire        da_vld, res_vld, acc, start, col, busy, chan;
    wire [47:0] da;
    wire [5:0]  hash;
    wire [3:0]  att;
    reg  [31:0] d0, d1;
    reg  [63:0] tbl;
    reg  [47:0] a;
    integer     n_errors = 0, samples_checked = 0, cycles = 0, i;
    maf_top maf_top_i (.clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .rx_da_valid_in(da_vld), .rx_da_in(da),
        .rx_result_valid_out(res_vld), .rx_accept_out(acc),
        .rx_hash_out(hash), .tx_frame_start_in(start),
        .tx_collision_in(col), .tx_attempt_out(att),
        .tx_backoff_busy_out(busy), .channel_enabled_out(chan));
    maf_mac_model maf_mac_model_i (.clk_in(clk), .rx_da_valid_out(da_vld),
        .rx_da_out(da), .tx_frame_start_out(start), .tx_collision_out(col));
    always #25 clk = ~clk;
    // ====================
    // Shared helpers
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [7:0] a_in, input [31:0] d_in);
        begin
            @(posedge clk);
            addr <= a_in;
            wdata <= d_in;
            wr <= 1'h1;
            @(posedge clk);
            wr <= 1'h0;
            #1;
        end
    endtask
    task rreg(input [7:0] a_in, output [31:0] d_out);
        begin
            @(posedge clk);
            addr <= a_in;
            rd <= 1'h1;
            @(posedge clk);
            rd <= 1'h0;
            #1 d_out = rdata;
        end
    endtask
    function [5:0] hash6(input [47:0] v);
        integer k;
        begin
            hash6 = 6'h0;
            for (k = 0; k < 48; k = k + 1)
                hash6[k % 6] = hash6[k % 6] ^ v[k];
        end
    endfunction
    task summarize;
        begin
            if (n_errors == 0 && samples_checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // ====================
    // Scenarios
    task t_rng;
        begin
            rreg(8'h0c, d0);
            chk({31'h0, d0[26:16] < 11'h3}, 32'h1);
            rreg(8'h0c, d1);
            chk(d1, {5'h0, d0[26:16] + 11'h2, 16'h0});
        end
    endtask
    task t_regs;
        begin
            for (i = 0; i < 32; i = i + 4)
                if (i != 12)
                begin
                    rreg(i[7:0], d0);
                    chk(d0, 32'h0);
                end
            wreg(8'h1c, 32'hffff_ffff);
            rreg(8'h1c, d0);
            chk(d0, 32'h0);
            wreg(8'h00, 32'hffff_ffff);
            rreg(8'h00, d0);
            chk(d0, 32'hffff_fffe);
        end
    endtask
    task t_hash;
        begin
            wreg(8'h10, 32'h4);
            tbl = 64'h3c3c_f00f_5a5a_0ff0;
            wreg(8'h04, tbl[31:0]);
            wreg(8'h08, tbl[63:32]);
            rreg(8'h08, d0);
            chk(d0, tbl[63:32]);
            for (i = 0; i < 16; i = i + 1)
            begin
                a = 48'h0100_0000_0000 | (48'h2a5f_31c7_9e4d * i);
                maf_mac_model_i.send_da(a);
                chk({24'h0, res_vld, hash, acc},
                    {24'h0, 1'h1, hash6(a), tbl[hash6(a)]});
            end
            wreg(8'h04, 32'hffff_ffff);
            wreg(8'h08, 32'hffff_ffff);
            maf_mac_model_i.send_da(48'h0200_0000_0001);
            chk({31'h0, acc}, 32'h0);
        end
    endtask
    task t_chan;
        begin
            wreg(8'h10, 32'h6);
            wreg(8'h14, 32'h5c);
            chk({31'h0, chan}, 32'h0);
            wreg(8'h00, 32'h4433_2210);
            chk({31'h0, chan}, 32'h1);
            maf_mac_model_i.send_da(48'h1022_3344_995c);
            chk({31'h0, acc}, 32'h1);
            wreg(8'h14, 32'h5c);
            maf_mac_model_i.send_da(48'h1022_3344_995c);
            chk({31'h0, acc}, 32'h0);
        end
    endtask
    task t_gate;
        begin
            wreg(8'h0c, 32'h2800_0000);
            chk({28'h0, att}, 32'h0);
            wreg(8'h10, 32'h1);
            wreg(8'h0c, 32'h2c00_0c00);
            chk({28'h0, att}, 32'h5);
            rreg(8'h0c, d0);
            chk({d0[31:27], d0[15:0]}, {5'h05, 16'h0});
            chk({31'h0, d0[26:16] - 11'h400 < 11'h3}, 32'h1);
        end
    endtask
    // Read spacing of 306 cycles spans exactly three slot ticks
    task t_count;
        begin
            wreg(8'h0c, 32'h0000_000a);
            chk({31'h0, busy}, 32'h1);
            rreg(8'h0c, d0);
            repeat (304) @(posedge clk);
            rreg(8'h0c, d1);
            chk({22'h0, d0[9:0] - d1[9:0]}, 32'h3);
        end
    endtask
    task t_collide;
        begin
            maf_mac_model_i.pulse(1'h0);
            chk({28'h0, att}, 32'h0);
            for (i = 1; i < 18; i = i + 1)
            begin
                maf_mac_model_i.pulse(1'h1);
                chk({28'h0, att}, (i > 15) ? 32'hf : i);
                if (i == 3)
                begin
                    rreg(8'h0c, d0);
                    chk(d0 & 32'h7800_03f8, 32'h1800_0000);
                end
            end
            maf_mac_model_i.pulse(1'h0);
            chk({28'h0, att}, 32'h0);
        end
    endtask
    initial
    begin
        clk = 1'h0;
        rst_n <= 1'h0;
        addr <= 8'h00;
        wdata <= 32'h0;
        wr <= 1'h0;
        rd <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_rng;
        t_regs;
        t_hash;
        t_chan;
        t_gate;
        t_count;
        t_collide;
        summarize;
    end
    // Whole run needs about 450 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
endmodule
